// ---- seq_defs.vh ----
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH
// Clocks per instruction cycle
`define CLKS_PER_ICYC 4
`define PHASE_LAST 2'h3
// Instruction class codes (5 bits)
`define OP_NOP 5'h00
`define OP_ADD 5'h01
`define OP_ADC 5'h02
`define OP_SUB 5'h03
`define OP_SBC 5'h04
`define OP_AND 5'h05
`define OP_OR 5'h06
`define OP_XOR 5'h07
`define OP_CPL 5'h08
`define OP_INC 5'h09
`define OP_DEC 5'h0A
`define OP_RR 5'h0B
`define OP_RL 5'h0C
`define OP_RRC 5'h0D
`define OP_RLC 5'h0E
`define OP_MOVAM 5'h0F
`define OP_MOVMA 5'h10
`define OP_MOVAX 5'h11
`define OP_CLRB 5'h12
`define OP_SETB 5'h13
`define OP_JMP 5'h14
`define OP_CALL 5'h15
`define OP_RET 5'h16
`define OP_INTERRUPT_RETURN 5'h17
`define OP_SZ 5'h18
`define OP_SNZ 5'h19
`define OP_SZB 5'h1A
`define OP_SNZB 5'h1B
`define OP_TABRD 5'h1C
`define OP_HALT 5'h1D
`define OP_CLRM 5'h1E
// Instruction word fields: [15:11] op, [10] dest is memory, [9:0] operand
`define F_OP_HI 15
`define F_OP_LO 11
`define F_DEST 10
`define F_BIT_HI 9
`define F_BIT_LO 7
// Address of the program counter low byte in data memory sector 0
`define PCL_ADDR 7'h06
`define PC_RESET 11'h000
`endif

// ---- cycle_timer.v ----
`timescale 1ns/1ps
`include "seq_defs.vh"
// Phase counter marking instruction cycle boundaries
module cycle_timer (
   input wire clk,
   input wire reset,
   input wire run,
   output reg [1:0] phase_r,
   output wire icyc_end
);
   // ****************************************
   // Phase count
   // ****************************************
   assign icyc_end = run & (phase_r == `PHASE_LAST);
   // Stalls while halted so the next cycle starts cleanly at phase 0
   always @(posedge clk) begin
      if (reset) begin
         phase_r <= 2'h0;
      end else if (run) begin
         phase_r <= phase_r + 2'h1;
      end
   end
endmodule

// ---- alu8.v ----
`timescale 1ns/1ps
`include "seq_defs.vh"
// Combinational 8-bit arithmetic, logic and rotate unit
module alu8 (
   input wire [4:0] op,
   input wire [7:0] acc,
   input wire [7:0] mem,
   input wire [7:0] imm,
   input wire use_imm,
   input wire [2:0] bit_sel,
   input wire carry_in,
   input wire zero_in,
   output reg [7:0] result,
   output reg carry_out,
   output reg zero_out
);
   reg [8:0] wide;
   reg [7:0] opnd;
   // ****************************************
   // Operation select
   // ****************************************
   always @* begin
      wide = 9'h000;
      opnd = use_imm ? imm : mem;
      result = opnd;
      carry_out = carry_in;
      zero_out = zero_in;
      case (op)
         `OP_ADD, `OP_ADC: begin
            wide = {1'b0, acc} + {1'b0, opnd}
               + {8'h00, (op == `OP_ADC) & carry_in};
            result = wide[7:0];
            carry_out = wide[8];
            zero_out = (wide[7:0] == 8'h00);
         end
         `OP_SUB, `OP_SBC: begin
            // Carry high means no borrow
            wide = {1'b0, acc} - {1'b0, opnd}
               - {8'h00, (op == `OP_SBC) & ~carry_in};
            result = wide[7:0];
            carry_out = ~wide[8];
            zero_out = (wide[7:0] == 8'h00);
         end
         `OP_AND: begin
            result = acc & opnd;
            zero_out = (result == 8'h00);
         end
         `OP_OR: begin
            result = acc | opnd;
            zero_out = (result == 8'h00);
         end
         `OP_XOR: begin
            result = acc ^ opnd;
            zero_out = (result == 8'h00);
         end
         `OP_CPL: begin
            result = ~mem;
            zero_out = (result == 8'h00);
         end
         `OP_INC: begin
            result = mem + 8'h01;
            zero_out = (result == 8'h00);
         end
         `OP_DEC: begin
            result = mem - 8'h01;
            zero_out = (result == 8'h00);
         end
         `OP_RR: result = {mem[0], mem[7:1]};
         `OP_RL: result = {mem[6:0], mem[7]};
         `OP_RRC: begin
            result = {carry_in, mem[7:1]};
            carry_out = mem[0];
         end
         `OP_RLC: begin
            result = {mem[6:0], carry_in};
            carry_out = mem[7];
         end
         `OP_MOVMA: result = acc;
         `OP_CLRB: result = mem & ~(8'h01 << bit_sel);
         `OP_SETB: result = mem | (8'h01 << bit_sel);
         `OP_CLRM: result = 8'h00;
         default: result = opnd;
      endcase
   end
endmodule

// ---- mcu_instruction_sequencer.v ----
`timescale 1ns/1ps
`include "seq_defs.vh"
module mcu_instruction_sequencer #(
   parameter PC_W = 11,
   parameter STACK_DEPTH = 8
) (
   input wire clk,
   input wire reset,
   input wire [15:0] instr,
   input wire [15:0] table_data,
   input wire [7:0] mem_rdata,
   input wire wake,
   output reg [PC_W-1:0] pmem_addr_r,
   output reg [6:0] dmem_addr_r,
   output reg [7:0] dmem_wdata_r,
   output reg dmem_we_r,
   output reg [7:0] acc_r,
   output reg carry_r,
   output reg zero_r,
   output reg global_interrupt_enable_r,
   output reg [7:0] table_low_r,
   output reg halted_r,
   output reg extra_cycle_r
);
   // ****************************************
   // Declarations
   // ****************************************
   localparam S_EXEC = 2'h0;
   localparam S_EXTRA = 2'h1;
   localparam S_HALT = 2'h2;
   localparam SP_W = 3;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [PC_W-1:0] pc_r;
   reg [PC_W-1:0] pc_nxt;
   reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
   reg [SP_W-1:0] sp_r;
   reg [15:0] ir_r;
   reg wake_meta_r;
   reg wake_sync_r;
   reg need_extra;
   reg skip_taken;
   reg mem_write;
   wire [1:0] phase;
   wire icyc_end;
   wire [4:0] op;
   wire dest_mem;
   wire [2:0] bit_sel;
   wire [7:0] imm;
   wire [6:0] maddr;
   wire [7:0] alu_result;
   wire alu_carry;
   wire alu_zero;
   wire use_imm;
   wire pcl_write;
   wire [PC_W-1:0] ret_addr;
   wire [PC_W-1:0] pc_inc;
   wire commit;
   wire ir_is_table;
   wire table_end;

   // ****************************************
   // Field decode
   // ****************************************
   assign op = instr[`F_OP_HI:`F_OP_LO];
   assign dest_mem = instr[`F_DEST];
   assign bit_sel = instr[`F_BIT_HI:`F_BIT_LO];
   assign imm = instr[7:0];
   // Only sector 0 is reachable; the sector bits are not modelled
   assign maddr = instr[6:0];
   assign use_imm = (op == `OP_MOVAX) | ~dest_mem & instr[9]
      & (op <= `OP_XOR) & (op != `OP_NOP);
   assign pc_inc = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
   assign ret_addr = stack_mem[sp_r - 3'h1];

   // ****************************************
   // Sub-blocks
   // ****************************************
   cycle_timer u_timer (
      .clk(clk),
      .reset(reset),
      .run(state_r != S_HALT),
      .phase_r(phase),
      .icyc_end(icyc_end)
   );

   alu8 u_alu (
      .op(op),
      .acc(acc_r),
      .mem(mem_rdata),
      .imm(imm),
      .use_imm(use_imm),
      .bit_sel(bit_sel),
      .carry_in(carry_r),
      .zero_in(zero_r),
      .result(alu_result),
      .carry_out(alu_carry),
      .zero_out(alu_zero)
   );

   // ****************************************
   // Memory write decision
   // ****************************************
   // Writes that land on the low PC byte redirect the fetch
   always @* begin
      case (op)
         `OP_CPL, `OP_INC, `OP_DEC, `OP_RR, `OP_RL, `OP_RRC, `OP_RLC,
         `OP_ADD, `OP_ADC, `OP_SUB, `OP_SBC, `OP_AND, `OP_OR, `OP_XOR:
            mem_write = dest_mem;
         `OP_MOVMA, `OP_CLRB, `OP_SETB, `OP_CLRM: mem_write = 1'b1;
         default: mem_write = 1'b0;
      endcase
   end
   assign pcl_write = mem_write & (maddr == `PCL_ADDR);

   // ****************************************
   // Skip and extra cycle decode
   // ****************************************
   always @* begin
      skip_taken = 1'b0;
      case (op)
         `OP_SZ: skip_taken = (mem_rdata == 8'h00);
         `OP_SNZ: skip_taken = (mem_rdata != 8'h00);
         `OP_SZB: skip_taken = ~mem_rdata[bit_sel];
         `OP_SNZB: skip_taken = mem_rdata[bit_sel];
         default: skip_taken = 1'b0;
      endcase
      case (op)
         `OP_JMP, `OP_CALL, `OP_RET, `OP_INTERRUPT_RETURN, `OP_TABRD:
            need_extra = 1'b1;
         default: need_extra = pcl_write | skip_taken;
      endcase
   end

   // ****************************************
   // Next program counter
   // ****************************************
   always @* begin
      pc_nxt = pc_inc;
      case (op)
         `OP_JMP, `OP_CALL: pc_nxt = instr[PC_W-1:0];
         `OP_RET, `OP_INTERRUPT_RETURN: pc_nxt = ret_addr;
         default: begin
            if (pcl_write) begin
               pc_nxt = {pc_r[PC_W-1:8], alu_result};
            end else if (skip_taken) begin
               pc_nxt = pc_r + {{(PC_W-2){1'b0}}, 2'h2};
            end
         end
      endcase
   end

   // ****************************************
   // Sequencer state
   // ****************************************
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_EXEC: begin
            if (icyc_end) begin
               if (op == `OP_HALT) begin
                  state_nxt = S_HALT;
               end else if (need_extra) begin
                  state_nxt = S_EXTRA;
               end
            end
         end
         S_EXTRA: begin
            if (icyc_end) begin
               state_nxt = S_EXEC;
            end
         end
         S_HALT: begin
            if (wake_sync_r) begin
               state_nxt = S_EXEC;
            end
         end
         default: state_nxt = S_EXEC;
      endcase
   end

   // Wake comes from outside the clock domain
   always @(posedge clk) begin
      if (reset) begin
         wake_meta_r <= 1'b0;
         wake_sync_r <= 1'b0;
      end else begin
         wake_meta_r <= wake;
         wake_sync_r <= wake_meta_r;
      end
   end

   // ****************************************
   // Commit strobes
   // ****************************************
   // Instruction takes effect at the last phase of its first cycle
   assign commit = (state_r == S_EXEC) & icyc_end;
   // The held word names a table read; the live bus may already move on
   assign ir_is_table = (ir_r[`F_OP_HI:`F_OP_LO] == `OP_TABRD);
   assign table_end = (state_r == S_EXTRA) & icyc_end & ir_is_table;

   // ****************************************
   // Control state
   // ****************************************
   // Status outputs copy the next state, so they line up with it
   always @(posedge clk) begin
      if (reset) begin
         state_r <= S_EXEC;
         halted_r <= 1'b0;
         extra_cycle_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         halted_r <= (state_nxt == S_HALT);
         extra_cycle_r <= (state_nxt == S_EXTRA);
      end
   end

   // ****************************************
   // Program flow
   // ****************************************
   // Counter and held word move together, only at a commit
   always @(posedge clk) begin
      if (reset) begin
         pc_r <= `PC_RESET;
         ir_r <= 16'h0000;
      end else if (commit) begin
         ir_r <= instr;
         pc_r <= pc_nxt;
      end
   end

   // Fetch address; a table read borrows it during its extra cycle
   always @(posedge clk) begin
      if (reset) begin
         pmem_addr_r <= `PC_RESET;
      end else if (state_r == S_EXTRA && ir_is_table) begin
         pmem_addr_r <= {{(PC_W-8){1'b0}}, acc_r};
      end else begin
         pmem_addr_r <= pc_r;
      end
   end

   // Return stack; depth is not checked, so deep nesting wraps round
   // and overwrites the oldest return point
   always @(posedge clk) begin
      if (reset) begin
         sp_r <= 3'h0;
      end else if (commit) begin
         case (op)
            `OP_CALL: begin
               stack_mem[sp_r] <= pc_inc;
               sp_r <= sp_r + 3'h1;
            end
            `OP_RET, `OP_INTERRUPT_RETURN: sp_r <= sp_r - 3'h1;
            default: begin
            end
         endcase
      end
   end

   // Only the interrupt return raises the enable; a plain return keeps it
   always @(posedge clk) begin
      if (reset) begin
         global_interrupt_enable_r <= 1'b0;
      end else if (commit && op == `OP_INTERRUPT_RETURN) begin
         global_interrupt_enable_r <= 1'b1;
      end
   end

   // ****************************************
   // Data path
   // ****************************************
   // Accumulator and flags change only at a commit
   always @(posedge clk) begin
      if (reset) begin
         acc_r <= 8'h00;
         carry_r <= 1'b0;
         zero_r <= 1'b0;
      end else if (commit) begin
         carry_r <= alu_carry;
         zero_r <= alu_zero;
         case (op)
            `OP_ADD, `OP_ADC, `OP_SUB, `OP_SBC, `OP_AND, `OP_OR,
            `OP_XOR, `OP_CPL, `OP_INC, `OP_DEC, `OP_RR, `OP_RL,
            `OP_RRC, `OP_RLC: begin
               if (!dest_mem) begin
                  acc_r <= alu_result;
               end
            end
            `OP_MOVAM, `OP_MOVAX: acc_r <= alu_result;
            default: begin
            end
         endcase
      end
   end

   // Data memory port; the strobe lasts one clock so each commit that
   // writes memory writes exactly once, and a table read writes at its cycle end
   always @(posedge clk) begin
      if (reset) begin
         dmem_we_r <= 1'b0;
         dmem_addr_r <= 7'h00;
         dmem_wdata_r <= 8'h00;
      end else if (table_end) begin
         dmem_we_r <= 1'b1;
         dmem_addr_r <= ir_r[6:0];
         dmem_wdata_r <= table_data[7:0];
      end else begin
         dmem_we_r <= commit & mem_write;
         dmem_addr_r <= maddr;
         if (commit & mem_write) begin
            dmem_wdata_r <= alu_result;
         end
      end
   end

   // Table word arrives at the end of the extra cycle
   always @(posedge clk) begin
      if (reset) begin
         table_low_r <= 8'h00;
      end else if (table_end) begin
         table_low_r <= table_data[7:0];
      end
   end
endmodule

// ---- seq_chk_assertions.sv ----
`timescale 1ns/1ps
`include "seq_defs.vh"
// ****
// Port checker
// ****
module seq_chk (
   input wire clk,
   input wire reset,
   input wire [15:0] instr,
   input wire [7:0] mem_rdata,
   input wire dmem_we_r,
   input wire [7:0] acc_r,
   input wire carry_r,
   input wire zero_r,
   input wire global_interrupt_enable_r,
   input wire halted_r,
   input wire extra_cycle_r
);
   reg [1:0] ph;
   reg [7:0] acc_q, mem_q, imm_q;
   reg c_q;
   wire go = ph == 2'h3 && !extra_cycle_r && !halted_r;
   // Phase mirror; history lets checks see operands of the commit edge
   always @(posedge clk) begin
      // Stalls in power-down just as the sequencer's phase counter does
      ph <= reset ? 2'h0 : (halted_r ? ph : ph + 2'h1);
      acc_q <= acc_r;
      mem_q <= mem_rdata;
      imm_q <= instr[7:0];
      c_q <= carry_r;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_ext;
      $rose(extra_cycle_r) |-> ph == 2'h0 ##1 extra_cycle_r [*3]
         ##1 !extra_cycle_r;
   endproperty
   a_ext: assert property (p_ext) else $error("extra cycle length");
   property p_acc;
      acc_r != acc_q |-> ph == 2'h0;
   endproperty
   a_acc: assert property (p_acc) else $error("acc off boundary");
   property p_we;
      dmem_we_r |-> ph == 2'h0 ##1 !dmem_we_r;
   endproperty
   a_we: assert property (p_we) else $error("write strobe shape");
   property p_add;
      go && instr[15:9] == {`OP_ADD, 2'b01}
         |=> {carry_r, acc_r} == acc_q + imm_q;
   endproperty
   a_add: assert property (p_add) else $error("add sum or carry");
   property p_zero;
      go && !instr[10] &&
         instr[15:11] inside {`OP_AND, `OP_OR, `OP_XOR, `OP_CPL}
         |=> zero_r == (acc_r == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("logic zero flag");
   property p_rrc;
      go && instr[15:10] == {`OP_RRC, 1'b0}
         |=> acc_r == {c_q, mem_q[7:1]} && carry_r == mem_q[0];
   endproperty
   a_rrc: assert property (p_rrc) else $error("carry rotate");
   property p_interrupt_return;
      go && instr[15:11] == `OP_INTERRUPT_RETURN |=> global_interrupt_enable_r;
   endproperty
   a_interrupt_return: assert property (p_interrupt_return) else $error("enable not set");
   property p_halt;
      halted_r |=> $stable(acc_r) && !dmem_we_r;
   endproperty
   a_halt: assert property (p_halt) else $error("work while halted");
endmodule
bind mcu_instruction_sequencer seq_chk u_chk (.clk(clk), .reset(reset),
   .instr(instr), .mem_rdata(mem_rdata), .dmem_we_r(dmem_we_r),
   .acc_r(acc_r), .carry_r(carry_r), .zero_r(zero_r),
   .global_interrupt_enable_r(global_interrupt_enable_r),
   .halted_r(halted_r), .extra_cycle_r(extra_cycle_r));

// ---- mem_model.sv ----
`timescale 1ns/1ps
// ****
// Program and data memory
// ****
module mem_model (
   input wire clk,
   input wire [15:0] instr,
   input wire [10:0] pmem_addr_r,
   input wire [6:0] dmem_addr_r,
   input wire [7:0] dmem_wdata_r,
   input wire dmem_we_r,
   output wire [7:0] mem_rdata,
   output reg [15:0] table_data
);
   reg [7:0] ram [0:127];
   // Table words follow the low address byte, so a fetch from a wrong low byte shows
   always @(negedge clk) begin
      table_data <= {~pmem_addr_r[7:0], pmem_addr_r[7:0] ^ 8'hA5};
   end
   // Sector 0 only: seven address bits reach the array
   always @(posedge clk) begin
      if (dmem_we_r) begin
         ram[dmem_addr_r] <= dmem_wdata_r;
      end
   end
   assign mem_rdata = ram[instr[6:0]];
endmodule

// ---- mcu_instruction_sequencer_tb.sv ----
`timescale 1ns/1ps
`include "seq_defs.vh"
// ****
// Sequencer bench
// ****
module mcu_instruction_sequencer_tb;
   typedef struct packed {
      logic ex, cp;
      logic [10:0] pc;
      logic [7:0] a;
      logic c, z, g;
   } note_t;
   reg clk = 0, reset = 1, wake = 0;
   reg [15:0] instr = 16'h0000;
   wire [15:0] tdat;
   wire [7:0] mrd, acc_r, dwd, tlow;
   wire [10:0] pma;
   wire [6:0] dwa;
   wire dwe, carry_r, zero_r, gie, halted_r, extra;
   note_t q[$], n, pn;
   reg [14:0] wq[$], w;
   reg [10:0] pc = 0;
   reg [7:0] a = 0;
   reg c = 0, z = 0, g = 0;
   reg [31:0] r;
   integer i, k, fails = 0, tests_run = 0;
   always #10 clk = ~clk;
   mcu_instruction_sequencer u_dut (.clk(clk), .reset(reset),
      .instr(instr), .table_data(tdat), .mem_rdata(mrd), .wake(wake),
      .pmem_addr_r(pma), .dmem_addr_r(dwa), .dmem_wdata_r(dwd),
      .dmem_we_r(dwe), .acc_r(acc_r), .carry_r(carry_r),
      .zero_r(zero_r), .global_interrupt_enable_r(gie),
      .table_low_r(tlow), .halted_r(halted_r), .extra_cycle_r(extra));
   mem_model u_mem (.clk(clk), .instr(instr), .pmem_addr_r(pma),
      .dmem_addr_r(dwa), .dmem_wdata_r(dwd), .dmem_we_r(dwe),
      .mem_rdata(mrd), .table_data(tdat));
   function [15:0] mk(input [4:0] op, input d, input [9:0] lo);
      mk = {op, d, lo};
   endfunction
   task check(input [15:0] seen, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Issue one instruction; a taken extra cycle owes a second note
   task step(input [15:0] ins, input ex, input cp);
      begin
         q.push_back({ex, cp, pc, a, c, z, g});
         if (ex) q.push_back({1'b0, 1'b0, pc, a, c, z, g});
         instr = ins;
         repeat (ex ? 8 : 4) @(negedge clk);
      end
   endtask
   task op1(input [15:0] ins, input [7:0] na, input nz);
      begin
         pc = pc + 11'h001;
         a = na;
         z = nz;
         step(ins, 1'b0, 1'b1);
      end
   endtask
   task skp(input [15:0] ins, input t);
      begin
         pc = pc + (t ? 11'h002 : 11'h001);
         step(ins, t, !t);
      end
   endtask
   // Commits land on every fourth edge after release
   initial begin
      @(negedge reset);
      pn = '0;
      forever begin
         repeat (4) @(posedge clk);
         #1;
         if (q.size() > 0) begin
            n = q.pop_front();
            check(extra, n.ex);
            check(acc_r, n.a);
            check(carry_r, n.c);
            check(zero_r, n.z);
            check(gie, n.g);
            // Fetch address trails the counter by one clock, so the
            // counter of the previous note shows now
            if (pn.cp) check(pma, pn.pc);
            pn = n;
         end
      end
   end
   // Counter low byte writes are jumps, not data results
   always @(negedge clk) begin
      if (dwe === 1'b1 && dwa !== `PCL_ADDR) begin
         w = wq.pop_front();
         check({dwa, dwd}, w);
      end
   end
   initial begin
      #100000;
      fails = fails + 1;
      end_sim;
   end
   initial begin
      for (i = 0; i < 128; i = i + 1) u_mem.ram[i] = i[7:0];
      r = $urandom(1755);
      repeat (4) @(negedge clk);
      reset = 0;
      for (k = 0; k < 4; k = k + 1) begin
         r = $urandom;
         op1(mk(`OP_MOVAX, 1'b0, {2'b10, r[7:0]}), r[7:0], z);
         {c, a} = a + r[15:8];
         op1(mk(`OP_ADD, 1'b0, {2'b10, r[15:8]}), a, a == 8'h00);
         c = a >= r[23:16];
         op1(mk(`OP_SUB, 1'b0, {2'b10, r[23:16]}), a - r[23:16],
            (a - r[23:16]) == 8'h00);
      end
      op1(mk(`OP_AND, 1'b0, 10'h200), 8'h00, 1'b1);
      op1(mk(`OP_OR, 1'b0, 10'h2A5), 8'hA5, 1'b0);
      op1(mk(`OP_XOR, 1'b0, 10'h2A5), 8'h00, 1'b1);
      op1(mk(`OP_CPL, 1'b0, 10'h07F), 8'h80, 1'b0);
      $display("arith and logic done");
      op1(mk(`OP_INC, 1'b0, 10'h07F), 8'h80, 1'b0);
      op1(mk(`OP_DEC, 1'b0, 10'h000), 8'hFF, 1'b0);
      wq.push_back({7'h20, 8'h21});
      op1(mk(`OP_INC, 1'b1, 10'h020), a, 1'b0);
      wq.push_back({7'h01, 8'h00});
      op1(mk(`OP_DEC, 1'b1, 10'h001), a, 1'b1);
      op1(mk(`OP_RR, 1'b0, 10'h041), 8'hA0, z);
      op1(mk(`OP_RL, 1'b0, 10'h041), 8'h82, z);
      r[7:0] = {c, 7'h01};
      c = 1'b1;
      op1(mk(`OP_RRC, 1'b0, 10'h003), r[7:0], z);
      c = 1'b0;
      op1(mk(`OP_RLC, 1'b0, 10'h040), 8'h81, z);
      wq.push_back({7'h10, 8'h18});
      op1(mk(`OP_SETB, 1'b1, {3'h3, 7'h10}), a, z);
      wq.push_back({7'h30, 8'h20});
      op1(mk(`OP_CLRB, 1'b1, {3'h4, 7'h30}), a, z);
      wq.push_back({7'h22, a});
      op1(mk(`OP_MOVMA, 1'b1, 10'h022), a, z);
      op1(mk(`OP_MOVAM, 1'b0, 10'h010), 8'h18, z);
      $display("memory ops done");
      skp(mk(`OP_SZ, 1'b1, 10'h001), 1'b1);
      skp(mk(`OP_SNZ, 1'b1, 10'h001), 1'b0);
      skp(mk(`OP_SZB, 1'b1, {3'h0, 7'h10}), 1'b1);
      skp(mk(`OP_SNZB, 1'b1, {3'h3, 7'h10}), 1'b1);
      skp(mk(`OP_SNZB, 1'b1, {3'h0, 7'h10}), 1'b0);
      $display("skips done");
      pc = 11'h040;
      step(mk(`OP_JMP, 1'b0, 10'h040), 1'b1, 1'b0);
      for (k = 0; k < 3; k = k + 1) begin
         r[10:0] = pc + 11'h001;
         pc = 11'h080;
         step(mk(`OP_CALL, 1'b0, 10'h080), 1'b1, 1'b0);
         if (k == 1) begin
            pc = 11'h0C0;
            step(mk(`OP_JMP, 1'b0, 10'h0C0), 1'b1, 1'b0);
         end
         pc = r[10:0];
         g = g | (k == 1);
         step(k == 1 ? 16'hB800 : 16'hB000, 1'b1, 1'b0);
         op1(16'h0000, a, z);
      end
      op1(mk(`OP_MOVAX, 1'b0, 10'h230), 8'h30, z);
      pc = 11'h030;
      step(mk(`OP_MOVMA, 1'b1, {3'h0, `PCL_ADDR}), 1'b1, 1'b0);
      op1(16'h0000, a, z);
      pc = 11'h000;
      step(mk(`OP_CLRM, 1'b1, {3'h0, `PCL_ADDR}), 1'b1, 1'b0);
      op1(16'h0000, a, z);
      $display("branches done");
      op1(mk(`OP_MOVAX, 1'b0, 10'h212), 8'h12, z);
      pc = pc + 11'h001;
      // Table byte for address 12 is also written to the operand address
      wq.push_back({7'h00, 8'hB7});
      step(mk(`OP_TABRD, 1'b0, 10'h000), 1'b1, 1'b0);
      check(tlow, 8'hB7);
      op1(16'h0000, a, z);
      op1(mk(`OP_HALT, 1'b0, 10'h000), a, z);
      check(halted_r, 1'b1);
      instr = mk(`OP_MOVAX, 1'b0, 10'h255);
      repeat (12) @(negedge clk);
      check(acc_r, a);
      instr = 16'h0000;
      wake = 1'b1;
      for (i = 0; i < 40 && halted_r !== 1'b0; i = i + 1) @(negedge clk);
      check(halted_r, 1'b0);
      check(q.size() + wq.size(), 16'h0000);
      $display("table and halt done");
      end_sim;
   end
endmodule
